//--- rtl/can_transceiver_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_mode_defines.svh"

// What this block does
// - Normal mode drives transmit stream onto bus
// - Normal mode: normal receiver feeds receive output
// - Normal mode: time-out disconnects transmitter
// - Normal mode: overtemperature disconnects transmitter
// - Normal mode: transmit supply loss forces receive-only
// - Logic supply loss always enters power-down
// - Low select enters normal with both supplies
// - Low select without transmit supply: receive-only, except from stand-by
// - Receive-only: transmitter off, normal receiver on
// - Receive-only and stand-by disable both protections
// - Receive-only watches supply, high select: stand-by
// - Power-down with low select leaves power-down
// - Stand-by: only low-power receiver is on
// - Stand-by: output follows bus after wake
// - Stand-by needs transmit supply to leave for normal
// - High select enters stand-by, swaps receivers
// - Stand-by never goes straight to receive-only
// - Power-down floats bus, resistors off
// - Power-up picks mode from select and supply
// - Undriven select reads as high
// - Bias half supply normal, ground in receive-only and stand-by
// - Low transmit is dominant, dominant reads low
// - Stand-by holds receive output high before wake
// - Time-out held until transmit rises
module can_transceiver_mode_control (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Controller side pins
    input  wire logic        txd,
    input  wire logic        standby_select,
    input  wire logic        standby_select_oe,
    // Supply and protection conditions
    input  wire logic        tx_supply_good,
    input  wire logic        logic_supply_good,
    input  wire logic        overtemp,
    input  wire logic        txd_timeout,
    // Receivers
    input  wire logic        wake_pattern,
    input  wire logic        bus_level,
    input  wire logic        bus_valid,
    output logic             bus_ready,
    // Receive data towards controller
    output logic             rxd,
    output logic             rxd_valid,
    input  wire logic        rxd_ready,
    // Bus side controls
    output logic             tx_enable,
    output logic             tx_dominant,
    output logic             normal_rx_en,
    output logic             lowpower_rx_en,
    output logic             bias_half,
    output logic             bias_gnd,
    output logic             input_res_en,
    output logic             timeout_supervise,
    output logic             overtemp_protect,
    output logic [1:0]       mode
);

    logic [`PIN_COUNT-1:0]   pin_raw;
    logic [`PIN_COUNT-1:0]   s1_q;
    logic [`PIN_COUNT-1:0]   s2_q;
    logic [`PIN_COUNT-1:0]   s3_q;
    logic [`PIN_COUNT-1:0]   pin_q;
    logic [`PIN_COUNT-1:0]   pin_d;
    xcvr_mode_pkg::mode_t    mode_q;
    xcvr_mode_pkg::mode_t    mode_d;
    logic                    txd_prev_q;
    logic                    timeout_q;
    logic                    timeout_d;
    logic                    wake_q;
    logic                    wake_d;
    logic                    stby_f;
    logic                    rx_src;
    logic [1:0]              cnt_q;
    logic [1:0]              cnt_d;
    logic                    head_q;
    logic                    head_d;
    logic                    tail_q;
    logic                    tail_d;
    logic                    push;
    logic                    pop;

    assign pin_raw = {wake_pattern, txd_timeout, overtemp, logic_supply_good,
                      tx_supply_good, standby_select_oe, standby_select, txd};

    // Three stages; a level counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_sync
            always_comb begin
                pin_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : pin_q[gi];
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1_q  <= `PIN_RST_VAL;
            s2_q  <= `PIN_RST_VAL;
            s3_q  <= `PIN_RST_VAL;
            pin_q <= `PIN_RST_VAL;
        end else begin
            s1_q  <= pin_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= pin_d;
        end
    end

    // Pull-up makes an undriven select a stand-by request
    assign stby_f = pin_q[`PIN_STB_DRV] ? pin_q[`PIN_STB_LVL] : 1'h1;

    // Mode selection; logic supply loss beats everything
    always_comb begin
        mode_d = mode_q;
        if (!pin_q[`PIN_LOG_GOOD]) begin
            mode_d = xcvr_mode_pkg::power_down;
        end else begin
            case (mode_q)
                xcvr_mode_pkg::power_down: begin
                    if (stby_f)
                        mode_d = xcvr_mode_pkg::standby;
                    else if (pin_q[`PIN_TX_GOOD])
                        mode_d = xcvr_mode_pkg::normal_op;
                    else
                        mode_d = xcvr_mode_pkg::forced_rx;
                end
                xcvr_mode_pkg::normal_op: begin
                    if (stby_f)
                        mode_d = xcvr_mode_pkg::standby;
                    else if (!pin_q[`PIN_TX_GOOD])
                        mode_d = xcvr_mode_pkg::forced_rx;
                end
                xcvr_mode_pkg::forced_rx: begin
                    if (stby_f)
                        mode_d = xcvr_mode_pkg::standby;
                    else if (pin_q[`PIN_TX_GOOD])
                        mode_d = xcvr_mode_pkg::normal_op;
                end
                xcvr_mode_pkg::standby: begin
                    // Without transmit supply a low select just waits here
                    if (!stby_f && pin_q[`PIN_TX_GOOD])
                        mode_d = xcvr_mode_pkg::normal_op;
                end
                default: mode_d = xcvr_mode_pkg::power_down;
            endcase
        end
    end

    // Time-out latch: set wins over the releasing edge
    always_comb begin
        timeout_d = timeout_q;
        if (!txd_prev_q && pin_q[`PIN_TXD])
            timeout_d = 1'h0;
        if (mode_q == xcvr_mode_pkg::normal_op && pin_q[`PIN_TIMEOUT])
            timeout_d = 1'h1;
    end

    // Wake flag lives only while in stand-by
    always_comb begin
        wake_d = wake_q;
        if (mode_q != xcvr_mode_pkg::standby)
            wake_d = 1'h0;
        else if (pin_q[`PIN_WAKE])
            wake_d = 1'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_q     <= xcvr_mode_pkg::power_down;
            txd_prev_q <= 1'h1;
            timeout_q  <= 1'h0;
            wake_q     <= 1'h0;
        end else begin
            mode_q     <= mode_d;
            txd_prev_q <= pin_q[`PIN_TXD];
            timeout_q  <= timeout_d;
            wake_q     <= wake_d;
        end
    end

    // Per-mode gating of the analog blocks
    always_comb begin
        normal_rx_en = (mode_q == xcvr_mode_pkg::normal_op) ||
                       (mode_q == xcvr_mode_pkg::forced_rx);
        lowpower_rx_en = (mode_q == xcvr_mode_pkg::standby);
        bias_half = (mode_q == xcvr_mode_pkg::normal_op);
        bias_gnd = (mode_q == xcvr_mode_pkg::forced_rx) ||
                   (mode_q == xcvr_mode_pkg::standby);
        input_res_en = (mode_q != xcvr_mode_pkg::power_down);
        timeout_supervise = (mode_q == xcvr_mode_pkg::normal_op);
        overtemp_protect = (mode_q == xcvr_mode_pkg::normal_op);
        tx_enable = (mode_q == xcvr_mode_pkg::normal_op) && !timeout_q &&
                    !pin_q[`PIN_OVERTEMP];
        tx_dominant = tx_enable && !pin_q[`PIN_TXD];
        mode = mode_q;
    end

    // Source of receive data: bus, or idle high
    always_comb begin
        case (mode_q)
            xcvr_mode_pkg::normal_op: rx_src = bus_level;
            xcvr_mode_pkg::forced_rx: rx_src = bus_level;
            xcvr_mode_pkg::standby:   rx_src = wake_q ? bus_level : `RXD_IDLE;
            default:                  rx_src = `RXD_IDLE;
        endcase
    end

    // Two-entry buffer; head is a flop so rxd never glitches
    assign bus_ready = (cnt_q != `BUF_DEPTH);
    assign rxd_valid = (cnt_q != 2'h0);
    assign push      = bus_valid && bus_ready;
    assign pop       = rxd_valid && rxd_ready;

    always_comb begin
        cnt_d  = cnt_q;
        head_d = head_q;
        tail_d = tail_q;
        case ({push, pop})
            2'b10: begin
                cnt_d = cnt_q + 2'h1;
                if (cnt_q == 2'h0)
                    head_d = rx_src;
                else
                    tail_d = rx_src;
            end
            2'b01: begin
                cnt_d  = cnt_q - 2'h1;
                head_d = (cnt_q == `BUF_DEPTH) ? tail_q : `RXD_IDLE;
            end
            2'b11: begin
                // Full cannot push, so one entry was here
                head_d = rx_src;
            end
            default: begin
                cnt_d = cnt_q;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_q  <= 2'h0;
            head_q <= `RXD_IDLE;
            tail_q <= `RXD_IDLE;
        end else begin
            cnt_q  <= cnt_d;
            head_q <= head_d;
            tail_q <= tail_d;
        end
    end

    assign rxd = head_q;

    // Checks on the mode logic
    chk_pd_on_loss: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !pin_q[`PIN_LOG_GOOD] |=> mode_q == xcvr_mode_pkg::power_down)
        else $error("logic supply loss did not power down");

    chk_normal_uv: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode_q == xcvr_mode_pkg::normal_op && pin_q[`PIN_LOG_GOOD] && !stby_f
         && !pin_q[`PIN_TX_GOOD]) |=> mode_q == xcvr_mode_pkg::forced_rx)
        else $error("supply loss in normal did not force receive-only");

    chk_stby_no_frx: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(mode_q) == xcvr_mode_pkg::standby |->
        mode_q != xcvr_mode_pkg::forced_rx)
        else $error("stand-by went straight to receive-only");

    chk_stby_enter: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode_q inside {xcvr_mode_pkg::normal_op, xcvr_mode_pkg::forced_rx}
         && stby_f && pin_q[`PIN_LOG_GOOD]) |=> lowpower_rx_en && !normal_rx_en && !tx_enable)
        else $error("high select did not enter stand-by");

    chk_stby_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode_q == xcvr_mode_pkg::standby && stby_f && pin_q[`PIN_LOG_GOOD])
        |=> mode_q == xcvr_mode_pkg::standby)
        else $error("stand-by left without a low select");

    chk_tx_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tx_enable |-> mode_q == xcvr_mode_pkg::normal_op && !pin_q[`PIN_OVERTEMP])
        else $error("transmitter on outside normal or while hot");

    chk_timeout_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (timeout_q && pin_q[`PIN_TXD] == txd_prev_q) |=> timeout_q && !tx_enable)
        else $error("time-out released without a rising edge");

    chk_wake_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode_q == xcvr_mode_pkg::standby && !wake_q && push)
        |=> cnt_q != 2'h0 && (cnt_q == `BUF_DEPTH || rxd == `RXD_IDLE))
        else $error("pre-wake push was lost or not idle");

    chk_rx_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cnt_q == 2'h0 && push && mode_q == xcvr_mode_pkg::standby && !wake_q)
        |=> rxd == `RXD_IDLE)
        else $error("receive output not idle before wake");

    chk_float_pd: assert property (@(posedge ref_clk) disable iff (sys_rst)
        mode_q == xcvr_mode_pkg::power_down |-> !input_res_en && !bias_half && !bias_gnd
        && !tx_enable)
        else $error("bus not floating in power-down");

    chk_buf_full: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cnt_q == `BUF_DEPTH && !rxd_ready) |=> !bus_ready && cnt_q == `BUF_DEPTH)
        else $error("buffer lost its full state");

endmodule : can_transceiver_mode_control
`default_nettype wire

//--- rtl/xcvr_mode_defines.svh
`ifndef XCVR_MODE_DEFINES_SVH
`define XCVR_MODE_DEFINES_SVH

// Positions in the pin synchroniser vector
`define PIN_TXD        0
`define PIN_STB_LVL    1
`define PIN_STB_DRV    2
`define PIN_TX_GOOD    3
`define PIN_LOG_GOOD   4
`define PIN_OVERTEMP   5
`define PIN_TIMEOUT    6
`define PIN_WAKE       7
`define PIN_COUNT      8

// Reset values and buffer depth
`define PIN_RST_VAL    8'h07
`define RXD_IDLE       1'h1
`define BUF_DEPTH      2'h2

`endif

//--- rtl/xcvr_mode_pkg.sv
`default_nettype none
package xcvr_mode_pkg;

    // Operating modes of the transceiver
    typedef enum logic [1:0] {
        power_down,
        normal_op,
        forced_rx,
        standby
    } mode_t;

endpackage : xcvr_mode_pkg
`default_nettype wire

//--- rtl/xcvr_mode_pkg_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- test/can_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural protocol controller on the pin side of the transceiver
module can_ctrl_model (
    // Clock
    input  wire logic       ref_clk,
    // Commands from the bench
    input  wire logic       tx_bit,
    input  wire logic       sel_high,
    input  wire logic       sel_drive,
    input  wire logic       stall,
    // Pins towards the transceiver
    output logic            txd,
    output logic            standby_select,
    output logic            standby_select_oe,
    input  wire logic       rxd,
    input  wire logic       rxd_valid,
    output logic            rxd_ready,
    // Received history, newest bit lowest
    output logic [7:0]      rx_hist,
    output logic [7:0]      rx_cnt
);
    // Low asks for dominant; a later rise releases a time-out
    assign txd               = tx_bit;
    // Released select floats to the pull-up level, never left unknown
    assign standby_select    = sel_drive ? sel_high : 1'h1;
    assign standby_select_oe = sel_drive;
    assign rxd_ready         = !stall;
    // Take each offered bit on the edge where valid and ready meet
    initial begin
        rx_hist = 8'h00;
        rx_cnt  = 8'h00;
    end
    always @(posedge ref_clk) begin
        if (rxd_valid && rxd_ready) begin
            rx_hist <= {rx_hist[6:0], rxd};
            rx_cnt  <= rx_cnt + 8'h01;
        end
    end
endmodule : can_ctrl_model
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       ref_clk, sys_rst, tx_bit, sel_high, sel_drive, stall;
    logic       txd, standby_select, standby_select_oe, rxd_ready;
    logic       tx_supply_good, logic_supply_good, overtemp, txd_timeout;
    logic       wake_pattern, bus_level, bus_valid, bus_ready, rxd, rxd_valid;
    logic       tx_enable, tx_dominant, normal_rx_en, lowpower_rx_en, bias_half;
    logic       bias_gnd, input_res_en, timeout_supervise, overtemp_protect;
    logic [1:0] mode;
    logic [7:0] rx_hist, rx_cnt, cnt0, ctl_vec;
    int         fails, check_count, cycles;
    assign ctl_vec = {tx_enable, normal_rx_en, lowpower_rx_en, bias_half,
                      bias_gnd, input_res_en, timeout_supervise, overtemp_protect};

    can_transceiver_mode_control can_transceiver_mode_control_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .txd(txd), .standby_select(standby_select),
        .standby_select_oe(standby_select_oe), .tx_supply_good(tx_supply_good),
        .logic_supply_good(logic_supply_good), .overtemp(overtemp), .txd_timeout(txd_timeout),
        .wake_pattern(wake_pattern), .bus_level(bus_level), .bus_valid(bus_valid),
        .bus_ready(bus_ready), .rxd(rxd), .rxd_valid(rxd_valid), .rxd_ready(rxd_ready),
        .tx_enable(tx_enable), .tx_dominant(tx_dominant), .normal_rx_en(normal_rx_en),
        .lowpower_rx_en(lowpower_rx_en), .bias_half(bias_half), .bias_gnd(bias_gnd),
        .input_res_en(input_res_en), .timeout_supervise(timeout_supervise),
        .overtemp_protect(overtemp_protect), .mode(mode));
    can_ctrl_model can_ctrl_model_inst (
        .ref_clk(ref_clk), .tx_bit(tx_bit), .sel_high(sel_high), .sel_drive(sel_drive),
        .stall(stall), .txd(txd), .standby_select(standby_select),
        .standby_select_oe(standby_select_oe), .rxd(rxd), .rxd_valid(rxd_valid),
        .rxd_ready(rxd_ready), .rx_hist(rx_hist), .rx_cnt(rx_cnt));

    // Free-running clock, 4 ns period
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Hang guard, far above the hundred or so cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // Pin to mode takes five edges, one more lets outputs settle
    task automatic settle;
        repeat (6) @(negedge ref_clk);
    endtask : settle
    task automatic check_mode(input logic [1:0] m, input logic [7:0] v);
        check("mode", {6'h00, m}, {6'h00, mode});
        check("enables", v, ctl_vec);
    endtask : check_mode
    // One bus sample offered for a single cycle, then drained
    task automatic push(input logic b);
        bus_valid = 1'h1;
        bus_level = b;
        @(negedge ref_clk);
        bus_valid = 1'h0;
        repeat (3) @(negedge ref_clk);
    endtask : push

    task automatic t_standby_entry;
        logic_supply_good = 1'h1;
        tx_supply_good    = 1'h1;
        settle();
        check_mode(xcvr_mode_pkg::standby, 8'h2c);
        tx_supply_good = 1'h0;
        sel_drive      = 1'h1;
        sel_high       = 1'h0;
        settle();
        check_mode(xcvr_mode_pkg::standby, 8'h2c);
        tx_supply_good = 1'h1;
        settle();
        check_mode(xcvr_mode_pkg::normal_op, 8'hd7);
    endtask : t_standby_entry

    task automatic t_normal_tx;
        tx_bit = 1'h0;
        settle();
        check("tx_dominant", 8'h01, {7'h00, tx_dominant});
        tx_bit   = 1'h1;
        overtemp = 1'h1;
        settle();
        check("tx_dominant", 8'h00, {7'h00, tx_dominant});
        check_mode(xcvr_mode_pkg::normal_op, 8'h57);
        overtemp    = 1'h0;
        txd_timeout = 1'h1;
        settle();
        check("tx_enable", 8'h00, {7'h00, tx_enable});
        txd_timeout = 1'h0;
        settle();
        check("tx_enable", 8'h00, {7'h00, tx_enable});
        tx_bit = 1'h0;
        settle();
        tx_bit = 1'h1;
        settle();
        check("tx_enable", 8'h01, {7'h00, tx_enable});
    endtask : t_normal_tx

    // Fill while the controller stalls, refuse a third, drain in order
    task automatic t_buffer;
        stall     = 1'h1;
        cnt0      = rx_cnt;
        bus_valid = 1'h1;
        bus_level = 1'h0;
        @(negedge ref_clk);
        bus_level = 1'h1;
        @(negedge ref_clk);
        bus_level = 1'h0;
        @(negedge ref_clk);
        bus_valid = 1'h0;
        check("full", 8'h01, {6'h00, bus_ready, rxd_valid});
        check("rxd_head", 8'h00, {7'h00, rxd});
        stall = 1'h0;
        repeat (4) @(negedge ref_clk);
        check("rx_cnt", cnt0 + 8'h02, rx_cnt);
        check("rx_order", 8'h01, {6'h00, rx_hist[1:0]});
        check("empty", 8'h02, {6'h00, rxd, rxd_valid});
    endtask : t_buffer

    task automatic t_forced;
        tx_supply_good = 1'h0;
        tx_bit         = 1'h0;
        settle();
        check_mode(xcvr_mode_pkg::forced_rx, 8'h4c);
        check("tx_dominant", 8'h00, {7'h00, tx_dominant});
        tx_bit   = 1'h1;
        sel_high = 1'h1;
        settle();
        check_mode(xcvr_mode_pkg::standby, 8'h2c);
    endtask : t_forced

    // Before wake the output stays recessive, afterwards it follows the bus
    task automatic t_wake;
        push(1'h0);
        check("rx_prewake", 8'h01, {7'h00, rx_hist[0]});
        wake_pattern = 1'h1;
        settle();
        push(1'h0);
        check("rx_postwake", 8'h00, {7'h00, rx_hist[0]});
    endtask : t_wake

    task automatic t_power;
        logic_supply_good = 1'h0;
        settle();
        check_mode(xcvr_mode_pkg::power_down, 8'h00);
        sel_high          = 1'h0;
        tx_supply_good    = 1'h0;
        logic_supply_good = 1'h1;
        settle();
        check_mode(xcvr_mode_pkg::forced_rx, 8'h4c);
    endtask : t_power

    task automatic finish_test;
        if (fails == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // Main sequence; supplies start off, select released
    initial begin
        {sys_rst, tx_bit, sel_high} = 3'h7;
        {sel_drive, stall, tx_supply_good, logic_supply_good} = 4'h0;
        {overtemp, txd_timeout, wake_pattern, bus_level, bus_valid} = 5'h00;
        repeat (6) @(negedge ref_clk);
        check_mode(xcvr_mode_pkg::power_down, 8'h00);
        check("reset_buf", 8'h05, {5'h00, rxd, rxd_valid, bus_ready});
        sys_rst = 1'h0;
        t_standby_entry();
        t_normal_tx();
        t_buffer();
        t_forced();
        t_wake();
        t_power();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
